// file: design/uart_ctl_pkg.sv
/*
 * Constants and carrier types for the UART control block.
 * Assumes one clock and a plain strobe register port.
 */
package uart_ctl_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFF_HOLDING   = 4'h0;  // Holding registers
    localparam logic [3:0] OFF_IRQ_EN    = 4'h1;  // irq_enable_reg
    localparam logic [3:0] OFF_IDENT     = 4'h2;  // Ident read, FIFO control write
    localparam logic [3:0] OFF_LINE_CTL  = 4'h3;  // line_control_reg
    localparam logic [3:0] OFF_MODEM_CTL = 4'h4;  // modem_control_reg
    localparam logic [3:0] OFF_LINE_STAT = 4'h5;  // line_status_reg
    localparam logic [3:0] OFF_MODEM_ST  = 4'h6;  // modem_status_reg
    localparam logic [3:0] OFF_DIV_LOW   = 4'h8;  // Divisor low byte
    localparam logic [3:0] OFF_DIV_HIGH  = 4'h9;  // divisor_high_byte
    localparam logic [3:0] OFF_ENH_FEAT  = 4'ha;  // enhanced_feature_reg
    localparam logic [3:0] OFF_FIFO_CTL  = 4'hb;  // fifo_control_reg readback

    // Interrupt identification codes
    localparam logic [5:0] ID_NONE      = 6'h01;
    localparam logic [5:0] ID_LINE_STAT = 6'h06;
    localparam logic [5:0] ID_RX_TMO    = 6'h0c;
    localparam logic [5:0] ID_RX_DATA   = 6'h04;
    localparam logic [5:0] ID_TX_EMPTY  = 6'h02;
    localparam logic [5:0] ID_MODEM     = 6'h00;
    localparam logic [5:0] ID_XOFF      = 6'h10;
    localparam logic [5:0] ID_FLOW_PIN  = 6'h20;

    // Field positions
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE_STAT = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_SLEEP = 4;
    localparam int IE_XOFF = 5;
    localparam int IE_FLOW_PIN = 7;
    localparam int FC_FIFO_EN = 0;
    localparam int FC_DMA_MODE = 3;
    localparam int LC_BREAK = 6;
    localparam int MC_PRESCALE = 7;
    localparam int EF_ENHANCED = 4;

    // Reset values
    localparam logic [7:0] LINE_CTL_RST = 8'h1d;

    // Timing
    localparam int PRESCALE_DIV = 4;        // Extra divide when selected
    localparam int OVERSAMPLE = 16;         // Baud ticks per bit
    localparam int IDLE_CHARS = 4;          // Idle length in characters
    localparam int BITS_PER_CHAR = 10;      // Start, eight data, stop
    localparam int IDLE_TICKS = IDLE_CHARS * BITS_PER_CHAR * OVERSAMPLE;
    localparam int MID_BIT = OVERSAMPLE / 2;

    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Status from the data path
    typedef struct packed {
        logic rxCount;       // Receive data held
        logic rxTrigger;     // Receive trigger reached
        logic rxTimeout;     // Stale receive data
        logic rxOverrun;     // Overrun pulse
        logic headError;     // Head character errored
        logic [2:0] headFlags; // Head break, framing, parity
        logic anyError;      // Any stored character errored
        logic txEmpty;       // Transmit FIFO and shifter empty
        logic txHoldEmpty;   // Transmit holding empty
        logic txTrigger;     // Transmit trigger passed
        logic txSpaces;      // Trigger count of spaces free
        logic txFull;        // Transmit FIFO full
        logic xoffSeen;      // Xoff pulse
        logic xonSeen;       // Xon pulse
        logic specialSeen;   // Special character pulse
        logic [3:0] modemDelta; // Modem change bits
    } dp_status_t;

endpackage : uart_ctl_pkg

// file: design/uart_irq_dma_sleep_baud.sv
/*
 * UART channel control: interrupt priority, DMA requests, sleep,
 * receive idle, break and the 16x baud tick.
 * Assumes FIFOs outside reporting via dp_status_t, inputs synchronous.
 */
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Enabled sources raise irq and code
// - Line errors highest, cleared by reads
// - Stale receive data gives time-out
// - Receive data or trigger interrupt
// - Transmit empty; ident read or holding write clears
// - Xoff/special; Xon or status read clears
// - Flow pin goes inactive; ident read clears
// - Error bit while errors remain
// - Head flags follow head, zero empty
// - Irq mode when low enables nonzero
// - Bit picks single or block DMA
// - Single mode requests track empty/held
// - Block transmit request by free space
// - Block receive request by trigger, timeout
// - Sleep needs both enables
// - Sleep only when idle, empty, quiet
// - Sleep stops clocks; activity wakes
// - Idle after four high characters
// - Break bit forces line low
// - 16-bit divisor makes 16x tick
// - Divide-by-4 prescaler, off at reset
// - Zero divisor gives no tick
// - Reset: ident 01, enables clear
module uart_irq_dma_sleep_baud #(
    parameter int IDLE_LIMIT = uart_ctl_pkg::IDLE_TICKS  // Baud ticks of high line
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire uart_ctl_pkg::reg_req_t  regReq,
    output logic [uart_ctl_pkg::DATA_W-1:0] regRdata,
    // Data path status and serial lines
    input  wire uart_ctl_pkg::dp_status_t dpStat,
    input  wire logic                    rxLine,
    input  wire logic                    txSerial,
    input  wire logic [3:0]              modemPins,
    input  wire logic                    rtsPin,
    input  wire logic                    ctsPin,
    // Outputs to pins and data path
    output logic                         txLine,
    output logic                         irqOut,
    output logic                         tx_dma_request_n,
    output logic                         rx_dma_request_n,
    output logic                         baudTick,
    output logic                         sleeping,
    output logic                         rxSample,
    output logic                         rxIdle
);
    import uart_ctl_pkg::*;

    // Software registers
    logic [7:0]  irqEnable_q; // irq_enable_reg
    logic [7:0]  fifoCtl_q; // fifo_control_reg
    logic [7:0]  lineCtl_q; // line_control_reg
    logic [7:0]  modemCtl_q; // modem_control_reg
    logic [7:0]  enhFeat_q; // enhanced_feature_reg
    logic [15:0] divisor_q; // Divisor, not reset
    // Interrupt pending flags
    logic        overrun_q; // Overrun latch
    logic        txIrq_q; // Transmit interrupt latch
    logic        xoffIrq_q; // Xoff cause
    logic        specIrq_q; // Special character cause
    logic        flowIrq_q; // Flow pin went inactive
    logic        rtsPrev_q; // Previous flow pin levels
    logic        ctsPrev_q;
    logic        txHoldPrev_q; // For empty edge detection
    logic [5:0]  ident; // Current identification code
    // Baud and idle state
    logic [1:0]  preCnt_q; // Prescaler counter
    logic [15:0] divCnt_q; // Divisor counter
    logic [15:0] idleCnt_q; // High line tick counter
    logic [3:0]  phase_q; // Tick phase within a bit
    logic        rxPrev_q; // Previous receive line
    logic [3:0]  modemPrev_q; // Previous modem pins

    // Decoded accesses
    logic identRd, statRd, holdRd, holdWr;
    assign identRd = regReq.rd && regReq.addr == OFF_IDENT;
    assign statRd  = regReq.rd && regReq.addr == OFF_LINE_STAT;
    assign holdRd  = regReq.rd && regReq.addr == OFF_HOLDING;
    assign holdWr  = regReq.wr && regReq.addr == OFF_HOLDING;

    // Divisor bytes; kept through reset on purpose
    always_ff @(posedge clk) begin
        if (regReq.wr && regReq.addr == OFF_DIV_LOW) begin
            divisor_q[7:0] <= regReq.wdata;
        end
        if (regReq.wr && regReq.addr == OFF_DIV_HIGH) begin
            divisor_q[15:8] <= regReq.wdata;
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqEnable_q <= 8'h00;
            fifoCtl_q   <= 8'h00;
            lineCtl_q   <= LINE_CTL_RST;
            modemCtl_q  <= 8'h00;
            enhFeat_q   <= 8'h00;
        end else if (regReq.wr) begin
            case (regReq.addr)
                OFF_IRQ_EN:    irqEnable_q <= regReq.wdata;
                OFF_IDENT:     fifoCtl_q   <= regReq.wdata;
                OFF_LINE_CTL:  lineCtl_q   <= regReq.wdata;
                OFF_MODEM_CTL: begin
                    // Prescaler bit locked unless enhanced on
                    modemCtl_q[6:0] <= regReq.wdata[6:0];
                    if (enhFeat_q[EF_ENHANCED]) begin
                        modemCtl_q[MC_PRESCALE] <= regReq.wdata[MC_PRESCALE];
                    end
                end
                OFF_ENH_FEAT:  enhFeat_q   <= regReq.wdata;
                default: ;
            endcase
        end
    end

    // Overrun latch; a new overrun beats the clearing read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overrun_q <= 1'b0;
        end else if (dpStat.rxOverrun) begin
            overrun_q <= 1'b1;
        end else if (statRd) begin
            overrun_q <= 1'b0;
        end
    end

    // Transmit interrupt latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txIrq_q      <= 1'b0;
            txHoldPrev_q <= 1'b1;
        end else begin
            txHoldPrev_q <= dpStat.txHoldEmpty;
            if ((fifoCtl_q[FC_FIFO_EN] ? dpStat.txTrigger
                                       : (dpStat.txHoldEmpty && !txHoldPrev_q))) begin
                txIrq_q <= 1'b1;
            end else if (identRd || holdWr) begin
                txIrq_q <= 1'b0;
            end
        end
    end

    // Xoff and special character interrupts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xoffIrq_q <= 1'b0;
            specIrq_q <= 1'b0;
        end else begin
            if (dpStat.xoffSeen) begin
                xoffIrq_q <= 1'b1;
            end else if (dpStat.xonSeen) begin
                xoffIrq_q <= 1'b0;
            end
            if (dpStat.specialSeen) begin
                specIrq_q <= 1'b1;
            end else if (statRd) begin
                specIrq_q <= 1'b0;
            end
        end
    end

    // Flow pin change from active low to inactive high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flowIrq_q <= 1'b0;
            rtsPrev_q <= 1'b1;
            ctsPrev_q <= 1'b1;
        end else begin
            rtsPrev_q <= rtsPin;
            ctsPrev_q <= ctsPin;
            // rising pin sets, ident read clears
            if ((rtsPin && !rtsPrev_q) || (ctsPin && !ctsPrev_q)) begin
                flowIrq_q <= 1'b1;
            end else if (identRd) begin
                flowIrq_q <= 1'b0;
            end
        end
    end

    // Priority encoder over enabled sources
    always_comb begin
        ident = ID_NONE;
        if (irqEnable_q[IE_LINE_STAT] && (overrun_q || dpStat.anyError)) begin
            ident = ID_LINE_STAT;
        end else if (irqEnable_q[IE_RX_DATA] && dpStat.rxTimeout) begin
            ident = ID_RX_TMO;
        end else if (irqEnable_q[IE_RX_DATA] &&
                     (fifoCtl_q[FC_FIFO_EN] ? dpStat.rxTrigger : dpStat.rxCount)) begin
            ident = ID_RX_DATA;
        end else if (irqEnable_q[IE_TX_EMPTY] && txIrq_q) begin
            ident = ID_TX_EMPTY;
        end else if (irqEnable_q[IE_MODEM] && |dpStat.modemDelta) begin
            ident = ID_MODEM;
        end else if (irqEnable_q[IE_XOFF] && (xoffIrq_q || specIrq_q)) begin
            ident = ID_XOFF;
        end else if (irqEnable_q[IE_FLOW_PIN] && flowIrq_q) begin
            ident = ID_FLOW_PIN;
        end
    end

    // Registered interrupt output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqOut <= 1'b0;
        end else begin
            // irq high whenever the ident code is not ID_NONE
            irqOut <= (ident != ID_NONE);
        end
    end

    // DMA requests, active low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_dma_request_n <= 1'b0;
            rx_dma_request_n <= 1'b1;
        end else if (!fifoCtl_q[FC_FIFO_EN] || !fifoCtl_q[FC_DMA_MODE]) begin
            tx_dma_request_n <= !dpStat.txHoldEmpty;
            rx_dma_request_n <= !dpStat.rxCount;
        end else begin
            if (dpStat.txFull) begin
                tx_dma_request_n <= 1'b1;
            end else if (dpStat.txSpaces) begin
                tx_dma_request_n <= 1'b0;
            end
            if (!dpStat.rxCount || dpStat.anyError) begin
                rx_dma_request_n <= 1'b1;
            end else if (dpStat.rxTrigger || dpStat.rxTimeout) begin
                rx_dma_request_n <= 1'b0;
            end
        end
    end

    // Sleep decision and wake
    logic sleepOk, wake;
    assign sleepOk = enhFeat_q[EF_ENHANCED] && irqEnable_q[IE_SLEEP] && rxIdle &&
                     dpStat.txEmpty && !dpStat.rxCount &&
                     (ident == ID_NONE || ident == ID_TX_EMPTY || ident == ID_RX_TMO);
    assign wake = (rxLine != rxPrev_q) || (modemPins != modemPrev_q) || holdWr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleeping    <= 1'b0;
            rxPrev_q    <= 1'b1;
            modemPrev_q <= 4'h0;
        end else begin
            rxPrev_q    <= rxLine;
            modemPrev_q <= modemPins;
            if (wake || !sleepOk) begin
                sleeping <= 1'b0;
            end else begin
                sleeping <= 1'b1;
            end
        end
    end

    // Baud tick: prescaler then divisor, halted asleep
    logic preEn;
    assign preEn = !modemCtl_q[MC_PRESCALE] || preCnt_q == 2'(PRESCALE_DIV - 1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCnt_q <= 2'h0;
            divCnt_q <= 16'h0001;
            baudTick <= 1'b0;
        end else if (sleeping || divisor_q == 16'h0000) begin
            baudTick <= 1'b0;
            divCnt_q <= 16'h0001;
        end else begin
            preCnt_q <= preEn ? 2'h0 : preCnt_q + 2'h1;
            baudTick <= 1'b0;
            if (preEn) begin
                if (divCnt_q >= divisor_q) begin
                    divCnt_q <= 16'h0001;
                    baudTick <= 1'b1;
                end else begin
                    divCnt_q <= divCnt_q + 16'h0001;
                end
            end
        end
    end

    // Receive idle and bit midpoint sampling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idleCnt_q <= 16'h0000;
            rxIdle    <= 1'b0;
            phase_q   <= 4'h0;
            rxSample  <= 1'b0;
        end else begin
            rxSample <= 1'b0;
            if (!rxLine) begin
                idleCnt_q <= 16'h0000;
                rxIdle    <= 1'b0;
                if (rxPrev_q) begin
                    phase_q <= 4'h0;
                end
            end else if (baudTick) begin
                if (idleCnt_q >= 16'(IDLE_LIMIT)) begin
                    rxIdle <= 1'b1;
                end else begin
                    idleCnt_q <= idleCnt_q + 16'h0001;
                end
            end
            if (baudTick) begin
                phase_q <= phase_q + 4'h1;
                rxSample <= (phase_q == 4'(MID_BIT - 1));
            end
        end
    end

    // Transmit line with break override
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txLine <= 1'b1;
        end else begin
            txLine <= lineCtl_q[LC_BREAK] ? 1'b0 : txSerial;
        end
    end

    // Read data one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regReq.rd) begin
            case (regReq.addr)
                OFF_IRQ_EN:    regRdata <= irqEnable_q;
                OFF_IDENT:     regRdata <= {fifoCtl_q[FC_FIFO_EN], fifoCtl_q[FC_FIFO_EN], ident};
                OFF_LINE_CTL:  regRdata <= lineCtl_q;
                OFF_MODEM_CTL: regRdata <= modemCtl_q;
                // aggregate error; head flags zero when empty
                OFF_LINE_STAT: regRdata <= {dpStat.anyError, dpStat.txEmpty,
                                            dpStat.txHoldEmpty,
                                            dpStat.rxCount ? dpStat.headFlags : 3'h0,
                                            overrun_q, dpStat.rxCount};
                OFF_MODEM_ST:  regRdata <= {modemPins, dpStat.modemDelta};
                OFF_DIV_LOW:   regRdata <= divisor_q[7:0];
                OFF_DIV_HIGH:  regRdata <= divisor_q[15:8];
                OFF_ENH_FEAT:  regRdata <= enhFeat_q;
                OFF_FIFO_CTL:  regRdata <= fifoCtl_q;
                default:       regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule // uart_irq_dma_sleep_baud

`default_nettype wire

// file: verification/uart_host_model.sv
/* Register port host: one-cycle strobes.
   Assumes read data stand one cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module uart_host_model
    import uart_ctl_pkg::*;
(
    // Clock and read data
    input  wire logic                 clk,
    input  wire logic [7:0]           regRdata,
    // Request to the device
    output var uart_ctl_pkg::reg_req_t regReq
);
    // Idle at time zero
    initial regReq = '0;
    // Released lines show inverted values
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // Data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, 8'hff};
        #1 d = regRdata;
    endtask
endmodule // uart_host_model
`default_nettype wire

// file: verification/uart_irq_dma_sleep_baud_asserts.sv
/* Port checker for the UART control block.
   Assumes a bind onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module uart_ctl_checker
    import uart_ctl_pkg::*;
(
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // Register port and status
    input wire uart_ctl_pkg::reg_req_t   regReq,
    input wire logic [7:0]               regRdata,
    input wire uart_ctl_pkg::dp_status_t dpStat,
    // Lines and requests
    input wire logic                     rxLine,
    input wire logic                     txLine,
    input wire logic                     irqOut,
    input wire logic                     tx_dma_request_n,
    input wire logic                     rx_dma_request_n,
    input wire logic                     baudTick,
    input wire logic                     sleeping,
    input wire logic                     rxIdle
);
    logic [7:0] ienQ;    // Shadow of the enables
    logic       brkQ;    // Shadow break bit
    logic       enhQ;    // Shadow enhanced bit
    logic [1:0] fcQ;     // Shadow block mode, FIFO on
    logic       single;  // Single-character DMA in force
    assign single = !(fcQ[0] && fcQ[1]);
    // Control bits shadowed from host writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ienQ <= 8'h00;
            brkQ <= 1'b0;
            enhQ <= 1'b0;
            fcQ  <= 2'b00;
        end else if (regReq.wr) begin
            case (regReq.addr)
                OFF_IRQ_EN:   ienQ <= regReq.wdata;
                OFF_IDENT:    fcQ <= {regReq.wdata[FC_DMA_MODE], regReq.wdata[FC_FIFO_EN]};
                OFF_LINE_CTL: brkQ <= regReq.wdata[LC_BREAK];
                OFF_ENH_FEAT: enhQ <= regReq.wdata[EF_ENHANCED];
                default:      ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rstLvl; disable iff (1'b0) !rst_n |=> regRdata == 8'h00 && txLine && !irqOut
        && !tx_dma_request_n && rx_dma_request_n && !baudTick && !sleeping && !rxIdle; endproperty
    a_rstLvl: assert property (p_rstLvl) else $error("reset levels wrong");
    property p_brk; brkQ && $past(brkQ) |-> !txLine; endproperty
    a_brk: assert property (p_brk) else $error("break line high");
    property p_quiet; ((ienQ | $past(ienQ) | $past(ienQ, 2)) & 8'hef) == 8'h00 |-> !irqOut;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq unenabled");
    property p_slpEn; sleeping |-> $past(enhQ) && $past(ienQ[IE_SLEEP]); endproperty
    a_slpEn: assert property (p_slpEn) else $error("sleep without enables");
    property p_slpClk; sleeping && $past(sleeping) |-> !baudTick; endproperty
    a_slpClk: assert property (p_slpClk) else $error("tick asleep");
    property p_rxOne; $past(rst_n) && single && $past(single)
        |-> rx_dma_request_n == !$past(dpStat.rxCount); endproperty
    a_rxOne: assert property (p_rxOne) else $error("rx request");
    property p_txBlk; !single && !$past(single) && $past(dpStat.txFull) |-> tx_dma_request_n;
    endproperty
    a_txBlk: assert property (p_txBlk) else $error("tx request while full");
    property p_idle; $past(rst_n) && !$past(rxLine) |-> !rxIdle; endproperty
    a_idle: assert property (p_idle) else $error("idle with line low");
endmodule // uart_ctl_checker
bind uart_irq_dma_sleep_baud uart_ctl_checker u_chk (
    .clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata), .dpStat(dpStat),
    .rxLine(rxLine), .txLine(txLine), .irqOut(irqOut), .tx_dma_request_n(tx_dma_request_n),
    .rx_dma_request_n(rx_dma_request_n), .baudTick(baudTick), .sleeping(sleeping),
    .rxIdle(rxIdle));
`default_nettype wire

// file: verification/uart_irq_dma_sleep_baud_tb.sv
/* UART control bench: host model plus status and lines.
   Assumes one 40 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_dma_sleep_baud_tb;
    import uart_ctl_pkg::*;
    logic       clk, rst_n;        // Clock and sync reset
    reg_req_t   regReq;            // Host request
    logic [7:0] regRdata, rdv;     // Read data
    dp_status_t dpStat;            // Data path status
    logic       rxLine, txSerial;  // Serial inputs
    logic       ctsPin;            // Flow pin under test
    logic       txLine, irqOut, txReq_n, rxReq_n;
    logic       baudTick, sleeping, rxSample, rxIdle;
    int         error_cnt, n_checks, ticks, i;
    // Free-running 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    uart_host_model u_host (.clk(clk), .regRdata(regRdata), .regReq(regReq));
    // Short idle limit keeps the run brief
    uart_irq_dma_sleep_baud #(.IDLE_LIMIT(8)) u_dut (
        .clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata), .dpStat(dpStat),
        .rxLine(rxLine), .txSerial(txSerial), .modemPins(4'h0), .rtsPin(1'b0),
        .ctsPin(ctsPin), .txLine(txLine), .irqOut(irqOut), .tx_dma_request_n(txReq_n),
        .rx_dma_request_n(rxReq_n), .baudTick(baudTick), .sleeping(sleeping),
        .rxSample(rxSample), .rxIdle(rxIdle));
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register read and compare
    task automatic rc(logic [3:0] a, logic [7:0] e, string what);
        u_host.rd(a, rdv);
        chk(what, rdv, e);
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask
    // Ticks seen over 60 cycles
    task automatic cnt();
        ticks = 0;
        repeat (60) begin
            @(posedge clk);
            #1 ticks += int'(baudTick);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    initial begin
        #2000000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        dpStat = '{txEmpty: 1'b1, default: 1'b0};
        rxLine = 1'b1;
        txSerial = 1'b1;
        ctsPin = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rc(OFF_IDENT, 8'h01, "ident");
        rc(OFF_IRQ_EN, 8'h00, "ienable");
        rc(4'h7, 8'h00, "unmapped");
        $display("reset test done");
        u_host.wr(OFF_IRQ_EN, 8'h02);
        @(posedge clk) dpStat.txHoldEmpty <= 1'b1;
        step(4);
        chk("irq", 8'(irqOut), 8'h01);
        rc(OFF_IDENT, {2'b00, ID_TX_EMPTY}, "ident tx");
        rc(OFF_IDENT, ID_NONE, "ident cleared");
        u_host.wr(OFF_IRQ_EN, 8'h05);
        @(posedge clk) dpStat.rxCount <= 1'b1;
        step(4);
        rc(OFF_IDENT, {2'b00, ID_RX_DATA}, "ident rx");
        chk("rx req", 8'(rxReq_n), 8'h00);
        @(posedge clk) dpStat.anyError <= 1'b1;
        dpStat.headFlags <= 3'b101;
        step(4);
        rc(OFF_IDENT, {2'b00, ID_LINE_STAT}, "ident prio");
        rc(OFF_LINE_STAT, 8'hf5, "status");
        @(posedge clk) dpStat.anyError <= 1'b0;
        step(4);
        rc(OFF_IDENT, {2'b00, ID_RX_DATA}, "ident err gone");
        @(posedge clk) dpStat.rxCount <= 1'b0;
        u_host.rd(OFF_HOLDING, rdv);
        step(4);
        rc(OFF_IDENT, ID_NONE, "ident rx read");
        chk("irq low", 8'(irqOut), 8'h00);
        rc(OFF_LINE_STAT, 8'h60, "status empty");
        $display("priority test done");
        u_host.wr(OFF_IRQ_EN, 8'ha0);
        @(posedge clk) dpStat.xoffSeen <= 1'b1;
        @(posedge clk) dpStat.xoffSeen <= 1'b0;
        step(3);
        rc(OFF_IDENT, {2'b00, ID_XOFF}, "ident xoff");
        @(posedge clk) dpStat.xonSeen <= 1'b1;
        @(posedge clk) dpStat.xonSeen <= 1'b0;
        step(3);
        rc(OFF_IDENT, ID_NONE, "ident xon");
        @(posedge clk) ctsPin <= 1'b1;
        step(3);
        rc(OFF_IDENT, {2'b00, ID_FLOW_PIN}, "ident pin");
        rc(OFF_IDENT, ID_NONE, "ident pin read");
        $display("flow test done");
        u_host.wr(OFF_IDENT, 8'h01);
        u_host.wr(OFF_IRQ_EN, 8'h01);
        @(posedge clk) dpStat.rxTimeout <= 1'b1;
        dpStat.rxCount <= 1'b1;
        step(4);
        rc(OFF_IDENT, {2'b11, ID_RX_TMO}, "ident tmo");
        u_host.wr(OFF_IDENT, 8'h09);
        @(posedge clk) dpStat.rxTrigger <= 1'b1;
        dpStat.txFull <= 1'b1;
        step(3);
        chk("blk rx req", 8'(rxReq_n), 8'h00);
        chk("blk tx full", 8'(txReq_n), 8'h01);
        @(posedge clk) dpStat.anyError <= 1'b1;
        dpStat.txFull <= 1'b0;
        dpStat.txSpaces <= 1'b1;
        step(3);
        chk("blk rx err", 8'(rxReq_n), 8'h01);
        chk("blk tx space", 8'(txReq_n), 8'h00);
        @(posedge clk) dpStat <= '{txEmpty: 1'b1, txHoldEmpty: 1'b1, default: 1'b0};
        u_host.rd(OFF_HOLDING, rdv);
        step(3);
        rc(OFF_IDENT, 8'hc1, "ident tmo read");
        $display("dma test done");
        u_host.wr(OFF_LINE_CTL, 8'h5d);
        step(3);
        chk("break", 8'(txLine), 8'h00);
        u_host.wr(OFF_LINE_CTL, LINE_CTL_RST);
        step(3);
        chk("no break", 8'(txLine), 8'h01);
        u_host.wr(OFF_DIV_LOW, 8'h03);
        u_host.wr(OFF_DIV_HIGH, 8'h00);
        step(20);
        cnt();
        chk("ticks div3", 8'(ticks), 8'd20);
        u_host.wr(OFF_ENH_FEAT, 8'h10);
        u_host.wr(OFF_MODEM_CTL, 8'h80);
        step(20);
        cnt();
        chk("ticks pre4", 8'(ticks), 8'd5);
        u_host.wr(OFF_MODEM_CTL, 8'h00);
        u_host.wr(OFF_DIV_LOW, 8'h00);
        step(20);
        cnt();
        chk("ticks div0", 8'(ticks), 8'd0);
        u_host.wr(OFF_DIV_LOW, 8'h03);
        for (i = 0; i < 200 && rxIdle !== 1'b1; i++) @(posedge clk);
        chk("idle", 8'(rxIdle), 8'h01);
        $display("baud test done");
        u_host.wr(OFF_IRQ_EN, 8'h10);
        for (i = 0; i < 200 && sleeping !== 1'b1; i++) @(posedge clk);
        chk("asleep", 8'(sleeping), 8'h01);
        cnt();
        chk("ticks asleep", 8'(ticks), 8'd0);
        @(posedge clk) rxLine <= 1'b0;
        for (i = 0; i < 8 && sleeping !== 1'b0; i++) @(posedge clk);
        chk("awake", 8'(sleeping), 8'h00);
        step(2);
        chk("not idle", 8'(rxIdle), 8'h00);
        for (i = 0; i < 60 && rxSample !== 1'b1; i++) begin @(posedge clk); #1; end
        chk("mid sample", 8'(rxSample), 8'h01);
        $display("sleep test done");
        give_verdict();
    end
endmodule // uart_irq_dma_sleep_baud_tb
`default_nettype wire
